// ---- rtl/lbdw_pkg.sv ----
// lbdw_pkg: constants and carrier types for the local bus decode and wake-up block
// assumes one 25 MHz board clock; local addresses are the low 16 bits of the processor bus
// Notes on behaviour
// - decoded channel-attention command raises the processor attention signal.
// - first init fetch returns bus-width switch on data bit 0, low means 16-bit.
// - local initialization reads return a transfer acknowledge ending the cycle.
// - reads of the second init address pair return all zeros.
// - reads of the third init pair assert the switch gate strobe.
// - wake-up block address is the switch value shifted left four bits.
// - only first attention after reset reads wake-up block; later ones skip it.
// - local write with bit 8 set to the interrupt port sets the latch.
// - host clear command clears the interrupt latch and releases the line, except in a cycle that also takes a setting write.
// - local reads in 0000H-1FFFH assert the ROM select.
// - local reads or writes in 4000H-47FFH assert the RAM select.
// - disk port range enables read decoder on read, write decoder on write.
// - enabled decoders pick one device from address bits 3 to 5.
// - port 8000H reads status; write drives control and enables gates.
// - write to 8008H clears index and ID-mismatch latches.
// - read 8018H raises second attention; write loads unit select register.
// - 8020H-8024H load or read counters; 8026H loads mode word.
// - port 8028H reads read buffer, writes write buffer.
// - 8030H write loads high comparator and starts format; 8038H loads low.
// - expansion port access asserts expansion select; bit 4 picks connector.
// - address bits 1 to 3 pass to both expansion connectors.
// - reset command asserts controller reset; clear command releases it.
package lbdw_pkg;

   // ****************************************
   // host wake-up commands
   // ****************************************
   localparam logic [7:0] CMD_CLEAR = 8'h00;
   localparam logic [7:0] CMD_ATTN = 8'h01;
   localparam logic [7:0] CMD_RESET = 8'h02;

   // ****************************************
   // initialization fetch addresses
   // ****************************************
   localparam logic [19:0] INIT_WIDTH_ADDR = 20'hFFFF6;
   localparam logic [19:0] INIT_ZERO_ADDR = 20'hFFFF8;
   localparam logic [19:0] INIT_SWS_ADDR = 20'hFFFFA;
   localparam int WAKE_SHIFT = 4;

   // ****************************************
   // local memory map
   // ****************************************
   localparam logic [15:0] ROM_LO = 16'h0000;
   localparam logic [15:0] ROM_HI = 16'h1FFF;
   localparam logic [15:0] RAM_LO = 16'h4000;
   localparam logic [15:0] RAM_HI = 16'h47FF;
   localparam logic [15:0] PORT_LO = 16'h8000;
   localparam logic [15:0] PORT_HI = 16'h803F;
   localparam logic [15:0] EXP_LO = 16'hC070;
   localparam logic [15:0] EXP_HI = 16'hC0EF;

   // ****************************************
   // disk control ports, index is address bits 5:3
   // ****************************************
   localparam logic [15:0] DISK_STATUS_AND_CONTROL = 16'h8000;
   localparam logic [15:0] LATCH_CLEAR_PORT = 16'h8008;
   localparam logic [15:0] DISK_CONTROL_REG = 16'h8010;
   localparam logic [15:0] UNIT_SELECT_AND_ATTENTION = 16'h8018;
   localparam logic [15:0] COUNTER_ZERO = 16'h8020;
   localparam logic [15:0] COUNTER_ONE = 16'h8022;
   localparam logic [15:0] COUNTER_TWO = 16'h8024;
   localparam logic [15:0] COUNTER_MODE_WORD = 16'h8026;
   localparam logic [15:0] DATA_BUFFER_PORT = 16'h8028;
   localparam logic [15:0] HIGH_ID_COMPARATOR = 16'h8030;
   localparam logic [15:0] LOW_ID_COMPARATOR = 16'h8038;
   localparam int PORT_SEL_LSB = 3;
   localparam int CNT_SEL_LSB = 1;
   localparam int IRQ_DATA_BIT = 8;
   localparam int EXP_CONN_BIT = 4;

   // control register fields driven by the drive-control port
   localparam int CTL_MARK_BIT = 0;
   localparam int CTL_DRIVE_READ_GATE_BIT = 1;
   localparam int CTL_WRGATE_BIT = 2;
   localparam logic [7:0] REG_RESET = 8'h00;

   // one local bus request
   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] wdata;
      logic rd;
      logic wr;
   } lbdw_req_t;

   // the decoded selects
   typedef struct packed {
      logic rom;
      logic ram;
      logic port;
      logic exp;
      logic init;
   } lbdw_sel_t;

endpackage

// ---- rtl/lbdw_top.sv ----
// lbdw_top: wake-up command decode, init fetch answers, interrupt latch and local decode
// assumes host and local bus strobes are synchronous to clock; switches are static straps
`timescale 1ns/10ps
module lbdw_top (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // host wake-up port
   input wire logic wake_wr,
   input wire logic [7:0] wake_data,
   // switches
   input wire logic wide_host_bus_n,
   input wire logic [15:0] wake_switches,
   // local bus
   input wire logic [19:0] local_addr,
   input wire logic [15:0] local_wdata,
   input wire logic local_read_cmd_n,
   input wire logic local_write_cmd_n,
   input wire logic [7:0] disk_status,
   input wire logic [7:0] counter_data,
   input wire logic [7:0] read_buffer,
   output logic [15:0] local_rdata,
   output logic local_rdata_oe_n,
   output logic xfer_ack,
   // wake-up and interrupt outputs
   output logic attention_strobe,
   output logic processor_attention_in,
   output logic chan2_attention,
   output logic board_reset_n,
   output logic host_irq_n,
   output logic wake_block_pending,
   output logic [19:0] wake_block_addr,
   output logic switch_gate_n,
   output logic host_data_bit0_n,
   // chip selects
   output logic rom_select_n,
   output logic ram_select_n,
   output logic expansion_select_n,
   output logic [1:0] exp_conn_select_n,
   output logic [2:0] exp_port_addr,
   // disk port strobes
   output logic rd_strobe_status,
   output logic rd_strobe_chan2_attn,
   output logic rd_strobe_counters,
   output logic rd_strobe_buffer,
   output logic wr_strobe_drive_ctl,
   output logic wr_strobe_latch_clear,
   output logic wr_strobe_control,
   output logic wr_strobe_unit_sel,
   output logic wr_strobe_counters,
   output logic wr_strobe_buffer,
   output logic wr_strobe_hi_compare,
   output logic wr_strobe_lo_compare,
   // disk side registers
   output logic mark_search_n,
   output logic drive_read_gate,
   output logic drive_write_gate,
   output logic latch_clear,
   output logic format_start,
   output logic [1:0] counter_index,
   output logic [7:0] unit_select_reg,
   output logic [7:0] counter_mode_reg,
   output logic [7:0] write_buffer_reg,
   output logic [7:0] hi_compare_reg,
   output logic [7:0] lo_compare_reg
);
   import lbdw_pkg::*;

   // ****************************************
   // wake-up command decode
   // ****************************************
   logic irq_ff, nxt_irq;
   logic rst_ff, nxt_rst;
   logic attn_ff;
   logic first_ff, nxt_first;
   logic [7:0] ctl_ff, unit_ff, mode_ff, wbuf_ff, hi_ff, lo_ff;
   logic [15:0] rdata_ff, nxt_rdata;
   logic ack_ff, oe_ff, gate_ff, c2_ff, clr_ff, fmt_ff;
   wire cmd_clear = wake_wr && (wake_data == CMD_CLEAR);
   wire cmd_attn = wake_wr && (wake_data == CMD_ATTN);
   wire cmd_reset = wake_wr && (wake_data == CMD_RESET);
   lbdw_req_t req;
   lbdw_sel_t sel;
   assign req = '{addr: local_addr, wdata: local_wdata,
                  rd: !local_read_cmd_n, wr: !local_write_cmd_n};

   // reset asserted by command, released by clear; clear wins only when no reset arrives
   assign nxt_rst = cmd_reset ? 1'b1 : (cmd_clear ? 1'b0 : rst_ff);

   // ****************************************
   // local address decode
   // ****************************************
   wire [15:0] a16 = req.addr[15:0];
   wire high_page = (req.addr[19:16] == 4'h0);
   wire acc = req.rd || req.wr;
   wire init_hit = req.rd && (req.addr[19:4] == INIT_WIDTH_ADDR[19:4]);
   wire in_rom = high_page && (a16 >= ROM_LO) && (a16 <= ROM_HI);
   wire in_ram = high_page && (a16 >= RAM_LO) && (a16 <= RAM_HI);
   wire in_port = high_page && (a16 >= PORT_LO) && (a16 <= PORT_HI);
   wire in_exp = high_page && (a16 >= EXP_LO) && (a16 <= EXP_HI);
   // only the init hit masks the other selects; rom, ram, port and exp stay exclusive because their ranges do not overlap
   assign sel.init = init_hit;
   assign sel.rom = !init_hit && req.rd && in_rom;
   assign sel.ram = !init_hit && acc && in_ram;
   assign sel.port = !init_hit && acc && in_port;
   assign sel.exp = !init_hit && acc && in_exp;
   assign rom_select_n = !sel.rom;
   assign ram_select_n = !sel.ram;
   assign expansion_select_n = !sel.exp;
   assign exp_conn_select_n[0] = !(sel.exp && !req.addr[EXP_CONN_BIT]);
   assign exp_conn_select_n[1] = !(sel.exp && req.addr[EXP_CONN_BIT]);
   assign exp_port_addr = req.addr[3:1];

   // ****************************************
   // disk port decoders
   // ****************************************
   wire rd_en = sel.port && req.rd;
   wire wr_en = sel.port && req.wr;
   wire [2:0] port_idx = req.addr[PORT_SEL_LSB +: 3];
   logic [7:0] rd_dec, wr_dec;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_dec
         assign rd_dec[gi] = rd_en && (port_idx == 3'(gi));
         assign wr_dec[gi] = wr_en && (port_idx == 3'(gi));
      end
   endgenerate
   // strobes are active high here; the board inverts them to its low-true enables
   assign rd_strobe_status = rd_dec[0];
   assign rd_strobe_chan2_attn = rd_dec[3];
   assign rd_strobe_counters = rd_dec[4];
   assign rd_strobe_buffer = rd_dec[5];
   assign wr_strobe_drive_ctl = wr_dec[0];
   assign wr_strobe_latch_clear = wr_dec[1];
   assign wr_strobe_control = wr_dec[2];
   assign wr_strobe_unit_sel = wr_dec[3];
   assign wr_strobe_counters = wr_dec[4];
   assign wr_strobe_buffer = wr_dec[5];
   assign wr_strobe_hi_compare = wr_dec[6];
   assign wr_strobe_lo_compare = wr_dec[7];
   wire mode_wr = wr_dec[4] && (req.addr[CNT_SEL_LSB +: 2] == 2'd3);
   assign counter_index = req.addr[CNT_SEL_LSB +: 2];

   // ****************************************
   // interrupt latch and attention tracking
   // ****************************************
   // a setting write in the same cycle as a host clear wins, so no request is lost
   wire irq_set = wr_dec[2] && req.wdata[IRQ_DATA_BIT];
   assign nxt_irq = irq_set ? 1'b1 : (cmd_clear ? 1'b0 : irq_ff);
   // the first attention after reset is flagged so the wake-up block is fetched
   assign nxt_first = cmd_reset ? 1'b1 : (cmd_attn ? 1'b0 : first_ff);

   // ****************************************
   // init fetch read data
   // ****************************************
   wire fetch_width = init_hit && (req.addr[3:1] == INIT_WIDTH_ADDR[3:1]);
   wire fetch_zero = init_hit && (req.addr[3:1] == INIT_ZERO_ADDR[3:1]);
   wire fetch_sws = init_hit && (req.addr[3:1] == INIT_SWS_ADDR[3:1]);
   always_comb begin
      nxt_rdata = 16'h0000;
      if (fetch_width) begin
         nxt_rdata[0] = wide_host_bus_n;
      end else if (fetch_zero) begin
         nxt_rdata = 16'h0000;
      end else if (fetch_sws) begin
         nxt_rdata = wake_switches;
      end else if (rd_dec[0]) begin
         nxt_rdata = {8'h00, disk_status};
      end else if (rd_dec[4]) begin
         nxt_rdata = {8'h00, counter_data};
      end else if (rd_dec[5]) begin
         nxt_rdata = {8'h00, read_buffer};
      end
   end

   // ****************************************
   // board state flops
   // ****************************************
   // wake-up state ignores the controller reset it itself produces
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rst_ff <= 1'b0;
         irq_ff <= 1'b0;
         attn_ff <= 1'b0;
         first_ff <= 1'b1;
      end else begin
         rst_ff <= nxt_rst;
         irq_ff <= nxt_irq;
         attn_ff <= cmd_attn;
         first_ff <= nxt_first;
      end
   end

   // read answers, one cycle after the command is seen
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rdata_ff <= 16'h0000;
         ack_ff <= 1'b0;
         oe_ff <= 1'b0;
         gate_ff <= 1'b0;
         c2_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         ack_ff <= sel.init;
         oe_ff <= init_hit || rd_en;
         gate_ff <= fetch_sws;
         c2_ff <= rd_dec[3];
      end
   end

   // disk-side registers, cleared by both resets
   wire dev_rst = reset || rst_ff;
   always_ff @(posedge clock or posedge dev_rst) begin
      if (dev_rst) begin
         ctl_ff <= REG_RESET;
         unit_ff <= REG_RESET;
         mode_ff <= REG_RESET;
         wbuf_ff <= REG_RESET;
         hi_ff <= REG_RESET;
         lo_ff <= REG_RESET;
         clr_ff <= 1'b0;
         fmt_ff <= 1'b0;
      end else begin
         if (wr_dec[0]) ctl_ff <= req.wdata[7:0];
         if (wr_dec[3]) unit_ff <= req.wdata[7:0];
         if (mode_wr) mode_ff <= req.wdata[7:0];
         if (wr_dec[5]) wbuf_ff <= req.wdata[7:0];
         if (wr_dec[6]) hi_ff <= req.wdata[7:0];
         if (wr_dec[7]) lo_ff <= req.wdata[7:0];
         clr_ff <= wr_dec[1];
         fmt_ff <= wr_dec[6];
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign attention_strobe = attn_ff;
   assign processor_attention_in = attn_ff;
   assign wake_block_pending = first_ff;
   assign wake_block_addr = {wake_switches, 4'h0};
   assign chan2_attention = c2_ff;
   assign board_reset_n = !rst_ff;
   assign host_irq_n = !irq_ff;
   assign switch_gate_n = !gate_ff;
   assign host_data_bit0_n = !rdata_ff[0];
   assign local_rdata = rdata_ff;
   assign local_rdata_oe_n = !oe_ff;
   assign xfer_ack = ack_ff;
   assign mark_search_n = !ctl_ff[CTL_MARK_BIT];
   assign drive_read_gate = ctl_ff[CTL_DRIVE_READ_GATE_BIT];
   assign drive_write_gate = ctl_ff[CTL_WRGATE_BIT];
   assign latch_clear = clr_ff;
   assign format_start = fmt_ff;
   assign unit_select_reg = unit_ff;
   assign counter_mode_reg = mode_ff;
   assign write_buffer_reg = wbuf_ff;
   assign hi_compare_reg = hi_ff;
   assign lo_compare_reg = lo_ff;
endmodule

// ---- verification/lbdw_top_assertions.sv ----
// lbdw_top_assertions: port-level checks for the wake-up and local decode block
// assumes it is bound onto lbdw_top; one clock, asynchronous active-high reset
`timescale 1ns/10ps
module lbdw_top_chk (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // causes
   input wire logic wake_wr,
   input wire logic [7:0] wake_data,
   input wire logic wide_host_bus_n,
   input wire logic [15:0] wake_switches,
   input wire logic [19:0] local_addr,
   input wire logic [15:0] local_wdata,
   input wire logic local_read_cmd_n,
   input wire logic local_write_cmd_n,
   // effects
   input wire logic [15:0] local_rdata,
   input wire logic xfer_ack,
   input wire logic attention_strobe,
   input wire logic board_reset_n,
   input wire logic host_irq_n,
   input wire logic wake_block_pending,
   input wire logic [19:0] wake_block_addr,
   input wire logic switch_gate_n,
   input wire logic rom_select_n,
   input wire logic ram_select_n,
   input wire logic expansion_select_n
);
   import lbdw_pkg::*;
   // ****
   // decoded causes
   // ****
   wire logic rd = !local_read_cmd_n;
   wire logic wr = !local_write_cmd_n;
   wire logic top = local_addr[19:4] == 16'hFFFF;
   wire logic irq_wr = wr && local_addr == {4'h0, DISK_CONTROL_REG} && local_wdata[IRQ_DATA_BIT];
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   init_ack_a: assert property (rd && top |=> xfer_ack) else $error("no ack");
   width_bit_a: assert property (rd && local_addr == INIT_WIDTH_ADDR |=>
      local_rdata[0] == $past(wide_host_bus_n)) else $error("width bit wrong");
   zero_fetch_a: assert property (rd && local_addr[19:1] == INIT_ZERO_ADDR[19:1] |=>
      local_rdata == 16'h0000) else $error("zero fetch not zero");
   switch_gate_a: assert property (rd && local_addr[19:1] == INIT_SWS_ADDR[19:1] |=>
      !switch_gate_n) else $error("switch gate missing");
   wake_addr_a: assert property (wake_block_addr == {wake_switches, 4'h0})
      else $error("wake block address wrong");
   attn_cmd_a: assert property (wake_wr && wake_data == CMD_ATTN |=>
      attention_strobe && !wake_block_pending) else $error("attention missing");
   attn_cause_a: assert property (attention_strobe |->
      $past(wake_wr) && $past(wake_data) == CMD_ATTN) else $error("stray attention");
   reset_cmd_a: assert property (wake_wr && wake_data == CMD_RESET |=>
      !board_reset_n ##1 !board_reset_n) else $error("reset not held");
   irq_set_a: assert property (irq_wr |=> !host_irq_n) else $error("irq not set");
   irq_clear_a: assert property (wake_wr && wake_data == CMD_CLEAR && !irq_wr |=>
      host_irq_n && board_reset_n) else $error("clear ignored");
   rom_sel_a: assert property (rd && local_addr <= 20'h01FFF |-> !rom_select_n)
      else $error("rom select missing");
   ram_sel_a: assert property ((rd || wr) && local_addr >= 20'h04000 &&
      local_addr <= 20'h047FF |-> !ram_select_n) else $error("ram select missing");
   one_select_a: assert property ($onehot0({!rom_select_n, !ram_select_n,
      !expansion_select_n})) else $error("selects overlap");
endmodule
bind lbdw_top lbdw_top_chk lbdw_top_chk_i (.*);

// ---- verification/lbdw_host_model.sv ----
// lbdw_host_model: host writer of the wake-up port, one command byte per request
// assumes the bench raises go for one cycle just after a rising edge
`timescale 1ns/10ps
module lbdw_host_model (
   // clock
   input wire logic clock,
   // request from the bench
   input wire logic go,
   input wire logic [7:0] cmd,
   // wake-up port
   output logic wake_wr,
   output logic [7:0] wake_data
);
   // ****
   // port driver
   // ****
   // data inverts each idle cycle, so on alternate idle cycles it equals the last command byte
   initial begin
      wake_wr = 1'b0;
      wake_data = 8'h5A;
      forever begin
         @(posedge clock);
         wake_wr <= go;
         wake_data <= go ? cmd : ~wake_data;
      end
   end
endmodule

// ---- verification/test_local_bus_decode_and_wakeup_init.sv ----
// test_local_bus_decode_and_wakeup_init: directed bench for lbdw_top
// assumes the package, lbdw_top, the host model and the checker are compiled first
`timescale 1ns/10ps
module test_local_bus_decode_and_wakeup_init;
   import lbdw_pkg::*;
   // ****
   // nets, instances, clock
   // ****
   logic clock, reset, go, wake_wr, wide_host_bus_n, local_read_cmd_n, local_write_cmd_n;
   logic [7:0] cmd, wake_data, disk_status, counter_data, read_buffer, wst, sel;
   logic [15:0] wake_switches, local_wdata, local_rdata;
   logic [19:0] local_addr, wake_block_addr;
   logic local_rdata_oe_n, xfer_ack, attention_strobe, processor_attention_in, chan2_attention;
   logic board_reset_n, host_irq_n, wake_block_pending, switch_gate_n, host_data_bit0_n;
   logic rom_select_n, ram_select_n, expansion_select_n, mark_search_n, drive_read_gate;
   logic drive_write_gate, latch_clear, format_start;
   logic [1:0] exp_conn_select_n, counter_index;
   logic [2:0] exp_port_addr;
   logic [3:0] rst;
   logic rd_strobe_status, rd_strobe_chan2_attn, rd_strobe_counters, rd_strobe_buffer;
   logic wr_strobe_drive_ctl, wr_strobe_latch_clear, wr_strobe_control, wr_strobe_unit_sel;
   logic wr_strobe_counters, wr_strobe_buffer, wr_strobe_hi_compare, wr_strobe_lo_compare;
   logic [7:0] unit_select_reg, counter_mode_reg, write_buffer_reg;
   logic [7:0] hi_compare_reg, lo_compare_reg;
   int mismatches = 0, checks_done = 0, cycles = 0;
   lbdw_top lbdw_top_i (.*);
   lbdw_host_model lbdw_host_model_i (.*);
   initial begin
      clock = 0;
      forever #20 clock = ~clock;
   end
   // a hang costs a mismatch; the whole run needs about 115 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         final_report;
      end
   end
   // ****
   // shared tasks
   // ****
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one local cycle; selects and strobes are captured while the command is held
   task automatic lb(input logic rd, input logic [19:0] a, input logic [15:0] d);
      @(posedge clock);
      #1;
      local_addr = a;
      local_wdata = d;
      local_read_cmd_n = !rd;
      local_write_cmd_n = rd;
      #2;
      sel = {rom_select_n, ram_select_n, expansion_select_n, exp_conn_select_n, exp_port_addr};
      rst = {rd_strobe_buffer, rd_strobe_counters, rd_strobe_chan2_attn, rd_strobe_status};
      wst = {wr_strobe_lo_compare, wr_strobe_hi_compare, wr_strobe_buffer, wr_strobe_counters,
         wr_strobe_unit_sel, wr_strobe_control, wr_strobe_latch_clear, wr_strobe_drive_ctl};
      @(posedge clock);
      #1;
      local_read_cmd_n = 1;
      local_write_cmd_n = 1;
   endtask
   // host command through the model; returns just after the design took it
   task automatic wk(input logic [7:0] c);
      @(posedge clock);
      #1;
      go = 1;
      cmd = c;
      @(posedge clock);
      #1;
      go = 0;
      @(posedge clock);
      #1;
   endtask
   task automatic m(input logic rd, input logic [19:0] a, input logic [2:0] s);
      lb(rd, a, 16'h0000);
      chk(sel[7:5], s);
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_wake;
      chk({wake_block_pending, board_reset_n, host_irq_n}, 3'b111);
      wk(CMD_RESET);
      chk(board_reset_n, 0);
      wk(CMD_CLEAR);
      chk(board_reset_n, 1);
      wk(CMD_ATTN);
      chk({attention_strobe, processor_attention_in, wake_block_pending}, 3'b110);
      @(posedge clock);
      #1;
      chk(attention_strobe, 0);
      wk(8'h07);
      chk({attention_strobe, board_reset_n}, 2'b01);
      wk(CMD_ATTN);
      chk({attention_strobe, wake_block_pending}, 2'b10);
   endtask
   task automatic t_fetch;
      for (int w = 0; w < 2; w++) begin
         wide_host_bus_n = w[0];
         lb(1, INIT_WIDTH_ADDR, 16'h0000);
         chk({xfer_ack, local_rdata_oe_n, local_rdata[0], host_data_bit0_n},
            {2'b10, w[0], !w[0]});
      end
      lb(1, INIT_ZERO_ADDR + 20'h1, 16'h0000);
      chk({xfer_ack, local_rdata}, {1'b1, 16'h0000});
      wake_switches = 16'hA5C3;
      lb(1, INIT_SWS_ADDR, 16'h0000);
      chk({xfer_ack, switch_gate_n, local_rdata}, {2'b10, 16'hA5C3});
      chk(wake_block_addr, 20'hA5C30);
   endtask
   task automatic t_irq;
      lb(0, DISK_CONTROL_REG, 16'h00FF);
      chk({wst, host_irq_n}, {8'h04, 1'b1});
      lb(0, DISK_CONTROL_REG, 16'h0100);
      chk(host_irq_n, 0);
      wk(8'h03);
      chk(host_irq_n, 0);
      // clear and a new setting write taken at one edge: the set must win
      fork
         wk(CMD_CLEAR);
         begin
            @(posedge clock);
            lb(0, DISK_CONTROL_REG, 16'h0100);
         end
      join
      chk(host_irq_n, 0);
      wk(CMD_CLEAR);
      chk(host_irq_n, 1);
   endtask
   task automatic t_map;
      m(1, 20'h00000, 3'b011);
      m(1, 20'h01FFF, 3'b011);
      m(0, 20'h01FFF, 3'b111);
      m(1, 20'h04000, 3'b101);
      m(0, 20'h047FF, 3'b101);
      m(1, 20'h04800, 3'b111);
      m(1, 20'h02000, 3'b111);
      chk({local_rdata_oe_n, local_rdata}, {1'b1, 16'h0000});
      m(0, 20'h0C07A, 3'b110);
      chk(sel[4:0], 5'b01101);
      m(1, 20'h0C0E6, 3'b110);
      chk(sel[4:0], 5'b10011);
   endtask
   task automatic t_ports;
      for (int i = 0; i < 8; i++) begin
         lb(0, 20'(PORT_LO) + 20'(i * 8), 16'h0007 + 16'(i * 16));
         chk({sel[7:5], wst}, {3'b111, 8'h01 << i});
         chk({latch_clear, format_start}, {i == 1, i == 6});
      end
      chk({mark_search_n, drive_read_gate, drive_write_gate, unit_select_reg},
         {3'b011, 8'h37});
      chk({write_buffer_reg, hi_compare_reg, lo_compare_reg}, 24'h576777);
      lb(1, DISK_STATUS_AND_CONTROL, 16'h0000);
      chk({rst, local_rdata[7:0]}, {4'b0001, 8'h3C});
      lb(1, UNIT_SELECT_AND_ATTENTION, 16'h0000);
      chk({rst, chan2_attention}, 5'b00101);
      lb(1, COUNTER_ONE, 16'h0000);
      chk({rst, counter_index, local_rdata[7:0]}, {6'b010001, 8'h96});
      lb(1, DATA_BUFFER_PORT, 16'h0000);
      chk({rst, local_rdata[7:0]}, {4'b1000, 8'hE1});
      lb(1, LATCH_CLEAR_PORT, 16'h0000);
      chk({rst, wst}, 12'h000);
      lb(0, COUNTER_MODE_WORD, 16'h005D);
      chk({wst, counter_mode_reg}, 16'h105D);
      wk(CMD_RESET);
      chk({drive_read_gate, drive_write_gate, wake_block_pending}, 3'b001);
      wk(CMD_CLEAR);
      // a board reset in mid-run brings back the first-attention state
      wk(CMD_ATTN);
      lb(0, DISK_CONTROL_REG, 16'h0100);
      reset = 1;
      @(posedge clock);
      #1;
      reset = 0;
      chk({wake_block_pending, host_irq_n, attention_strobe}, 3'b110);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // reset for twenty cycles, then the scenarios in order
   initial begin
      reset = 1;
      go = 0;
      cmd = 8'h00;
      wide_host_bus_n = 0;
      wake_switches = 16'h0000;
      local_addr = 20'h00000;
      local_wdata = 16'h0000;
      local_read_cmd_n = 1;
      local_write_cmd_n = 1;
      disk_status = 8'h3C;
      counter_data = 8'h96;
      read_buffer = 8'hE1;
      repeat (20) @(posedge clock);
      #1;
      reset = 0;
      t_wake;
      t_fetch;
      t_irq;
      t_map;
      t_ports;
      final_report;
   end
endmodule
